// *** core/dbu_pkg.sv ***
/*
  Constants and carrier types for the debug UART register block.
  Assumes a single 100 MHz system clock and a synchronous active-high reset.
*/
package dbu_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_COMMAND = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_IRQ_SET = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h0c;
  localparam logic [7:0] OFF_IRQ_VIEW = 8'h10;
  localparam logic [7:0] OFF_STATE = 8'h14;
  localparam logic [7:0] OFF_RX_HOLD = 8'h18;
  localparam logic [7:0] OFF_TX_HOLD = 8'h1c;
  localparam logic [7:0] OFF_BAUD = 8'h20;
  localparam logic [7:0] OFF_CHIP_ID = 8'h40;
  localparam logic [7:0] OFF_CHIP_EXT = 8'h44;
  localparam logic [7:0] OFF_TEST_LOCK = 8'h48;

  // ------------------------------------------------------------
  // Command bit positions
  // ------------------------------------------------------------
  localparam int CMD_RX_RESET = 2;
  localparam int CMD_TX_RESET = 3;
  localparam int CMD_RX_EN = 4;
  localparam int CMD_RX_DIS = 5;
  localparam int CMD_TX_EN = 6;
  localparam int CMD_TX_DIS = 7;
  localparam int CMD_ERR_CLR = 8;

  // ------------------------------------------------------------
  // Mode fields
  // ------------------------------------------------------------
  localparam int MODE_PAR_LO = 9;
  localparam int MODE_PAR_HI = 11;
  localparam int MODE_CH_LO = 14;
  localparam int MODE_CH_HI = 15;
  localparam logic [31:0] MODE_MASK = 32'h0000_ce00;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // Shared status / interrupt layout
  // ------------------------------------------------------------
  localparam int ST_RX_READY = 0;
  localparam int ST_TX_READY = 1;
  localparam int ST_RX_DMA_END = 3;
  localparam int ST_TX_DMA_END = 4;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAMING = 6;
  localparam int ST_PARITY = 7;
  localparam int ST_TX_IDLE = 9;
  localparam int ST_TX_BUF_EMPTY = 11;
  localparam int ST_RX_BUF_FULL = 12;
  localparam int ST_DBG_WRITE = 30;
  localparam int ST_DBG_READ = 31;
  localparam logic [31:0] IRQ_MASK = 32'hc000_1afb;
  localparam logic [31:0] IRQ_RESET = 32'h0000_0000;

  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [3:0] DATA_BITS = 4'h8;

  typedef enum logic [1:0] {
    CH_NORMAL = 2'h0,
    CH_ECHO = 2'h1,
    CH_LOCAL = 2'h2,
    CH_REMOTE = 2'h3
  } dbu_channel_test_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dbu_bus_req_t;

  typedef struct packed {
    logic rxDmaEnd;
    logic txDmaEnd;
    logic txDmaBufferEmpty;
    logic rxDmaBufferFull;
    logic debugWritePending;
    logic debugReadPending;
  } dbu_side_in_t;

endpackage

// *** core/dbu_uart.sv ***
/*
  Debug UART: register file, transmitter and receiver with test modes.
  Assumes a plain register port on clk_sys; serial input is asynchronous.
*/
`timescale 1ns/1ps
module dbu_uart #(
  parameter logic [31:0] CHIP_ID = 32'h1234_5678, // Arbitrary value
  parameter logic [31:0] CHIP_EXT = 32'h0000_0000 // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire dbu_pkg::dbu_bus_req_t busReq,
  output logic [31:0] busRdata,
  input wire dbu_pkg::dbu_side_in_t sideIn,
  input wire logic serialRxPin,
  output logic serialTxPin,
  output logic rxDmaRequest,
  output logic txDmaRequest,
  output logic testPortLock
);
  import dbu_pkg::*;

  // ------------------------------------------------------------
  // Registers and decode
  // ------------------------------------------------------------
  logic [31:0] mode_r;
  logic [31:0] irqMask_r;
  logic [15:0] baud_r;
  logic lock_r;
  logic receiver_enable_cmd_r;
  logic rxStop_r;
  logic transmitter_enable_cmd_r;
  logic txStop_r;
  logic [7:0] rxHold_r;
  logic rxReady_r;
  logic [7:0] txHold_r;
  logic txHoldFull_r;
  logic ovr_r;
  logic frm_r;
  logic par_r;
  logic [1:0] rxSync_r;
  logic [31:0] status;
  dbu_channel_test_mode_t channel_test_mode;
  logic [2:0] parSel;

  function automatic logic hit(input dbu_bus_req_t r, input logic [7:0] off);
    hit = r.addr == off;
  endfunction

  function automatic logic parityBit(input logic [7:0] d, input logic [2:0] sel);
    case (sel[1:0])
      2'h0: parityBit = ^d;
      2'h1: parityBit = ~^d;
      2'h2: parityBit = 1'b0;
      default: parityBit = 1'b1;
    endcase
  endfunction

  logic wrCmd;
  logic [31:0] cmd;
  assign wrCmd = busReq.wr && hit(busReq, OFF_COMMAND);
  assign cmd = busReq.wdata;
  assign channel_test_mode = dbu_channel_test_mode_t'(mode_r[MODE_CH_HI:MODE_CH_LO]);
  assign parSel = mode_r[MODE_PAR_HI:MODE_PAR_LO];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_r <= MODE_RESET;
      baud_r <= BAUD_RESET;
      lock_r <= 1'b0;
    end
    else if (busReq.wr)
    begin
      if (hit(busReq, OFF_MODE))
        mode_r <= busReq.wdata & MODE_MASK;
      if (hit(busReq, OFF_BAUD))
        baud_r <= busReq.wdata[15:0];
      if (hit(busReq, OFF_TEST_LOCK))
        lock_r <= busReq.wdata[0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      irqMask_r <= IRQ_RESET;
    else if (busReq.wr && hit(busReq, OFF_IRQ_SET))
      irqMask_r <= irqMask_r | (busReq.wdata & IRQ_MASK);
    else if (busReq.wr && hit(busReq, OFF_IRQ_CLEAR))
      irqMask_r <= irqMask_r & ~busReq.wdata;
  end

  // ------------------------------------------------------------
  // Baud tick
  // ------------------------------------------------------------
  logic [15:0] baudCnt_r;
  logic tick_r;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      baudCnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (baud_r == 16'h0000)
    begin
      baudCnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (baudCnt_r >= baud_r - 16'h0001)
    begin
      baudCnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end
    else
    begin
      baudCnt_r <= baudCnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rxSync_r <= 2'h3;
    else
      rxSync_r <= {rxSync_r[0], serialRxPin};
  end

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } dbu_txst_t;
  dbu_txst_t txSt_r;
  logic [7:0] txShift_r;
  logic [3:0] txSub_r;
  logic [3:0] txBit_r;
  logic txLine_r;
  logic txParity_r;
  logic txLoad;
  logic txBitEnd;
  assign txLoad = txSt_r == TX_IDLE && txHoldFull_r && transmitter_enable_cmd_r;
  assign txBitEnd = tick_r && txSub_r == 4'hf;

  always_ff @(posedge clk_sys)
  begin
    if (rst || (wrCmd && cmd[CMD_TX_RESET]))
    begin
      transmitter_enable_cmd_r <= 1'b0;
      txStop_r <= 1'b0;
    end
    else if (wrCmd && cmd[CMD_TX_EN] && !cmd[CMD_TX_DIS])
    begin
      transmitter_enable_cmd_r <= 1'b1;
      txStop_r <= 1'b0;
    end
    else if (wrCmd && cmd[CMD_TX_DIS])
      txStop_r <= 1'b1;
    else if (txStop_r && txSt_r == TX_IDLE && !txHoldFull_r)
    begin
      transmitter_enable_cmd_r <= 1'b0;
      txStop_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || (wrCmd && cmd[CMD_TX_RESET]))
    begin
      txHoldFull_r <= 1'b0;
      txHold_r <= 8'h00;
    end
    else if (busReq.wr && hit(busReq, OFF_TX_HOLD) && transmitter_enable_cmd_r && !txStop_r)
    begin
      txHoldFull_r <= 1'b1;
      txHold_r <= busReq.wdata[7:0];
    end
    else if (txLoad)
      txHoldFull_r <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || (wrCmd && cmd[CMD_TX_RESET]))
    begin
      txSt_r <= TX_IDLE;
      txShift_r <= 8'h00;
      txSub_r <= 4'h0;
      txBit_r <= 4'h0;
      txLine_r <= 1'b1;
      txParity_r <= 1'b0;
    end
    else
    begin
      if (tick_r)
        txSub_r <= txSub_r + 4'h1;
      case (txSt_r)
        TX_IDLE:
        begin
          txLine_r <= 1'b1;
          if (txLoad)
          begin
            txShift_r <= txHold_r;
            txParity_r <= parityBit(txHold_r, parSel);
            txSub_r <= 4'h0;
            txLine_r <= 1'b0;
            txSt_r <= TX_START;
          end
        end
        TX_START:
          if (txBitEnd)
          begin
            txLine_r <= txShift_r[0];
            txShift_r <= {1'b0, txShift_r[7:1]};
            txBit_r <= 4'h1;
            txSt_r <= TX_DATA;
          end
        TX_DATA:
          if (txBitEnd)
          begin
            if (txBit_r == DATA_BITS)
            begin
              txLine_r <= parSel[2] ? 1'b1 : txParity_r;
              txSt_r <= parSel[2] ? TX_STOP : TX_PAR;
            end
            else
            begin
              txLine_r <= txShift_r[0];
              txShift_r <= {1'b0, txShift_r[7:1]};
              txBit_r <= txBit_r + 4'h1;
            end
          end
        TX_PAR:
          if (txBitEnd)
          begin
            txLine_r <= 1'b1;
            txSt_r <= TX_STOP;
          end
        TX_STOP:
          if (txBitEnd)
            txSt_r <= TX_IDLE;
        default:
          txSt_r <= TX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_DATA = 4'h2,
    RX_PAR = 4'h4,
    RX_STOP = 4'h8
  } dbu_rxst_t;
  dbu_rxst_t rxSt_r;
  logic [7:0] rxShift_r;
  logic [3:0] rxSub_r;
  logic [3:0] rxBit_r;
  logic rxParErr_r;
  logic rxIn;
  logic rxSample;
  logic rxDone;
  logic rxRun;
  assign rxIn = channel_test_mode == CH_LOCAL ? txLine_r : rxSync_r[1];
  assign rxRun = receiver_enable_cmd_r && channel_test_mode != CH_REMOTE;
  assign rxSample = tick_r && rxSub_r == SAMPLE_MID;
  assign rxDone = rxSt_r == RX_STOP && rxSample;

  always_ff @(posedge clk_sys)
  begin
    if (rst || (wrCmd && cmd[CMD_RX_RESET]))
    begin
      receiver_enable_cmd_r <= 1'b0;
      rxStop_r <= 1'b0;
    end
    else if (wrCmd && cmd[CMD_RX_EN] && !cmd[CMD_RX_DIS])
    begin
      receiver_enable_cmd_r <= 1'b1;
      rxStop_r <= 1'b0;
    end
    else if (wrCmd && cmd[CMD_RX_DIS])
      rxStop_r <= 1'b1;
    else if (rxStop_r && (rxSt_r == RX_IDLE || rxDone))
    begin
      receiver_enable_cmd_r <= 1'b0;
      rxStop_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || (wrCmd && cmd[CMD_RX_RESET]) || !rxRun)
    begin
      rxSt_r <= RX_IDLE;
      rxShift_r <= 8'h00;
      rxSub_r <= 4'h0;
      rxBit_r <= 4'h0;
      rxParErr_r <= 1'b0;
    end
    else
    begin
      if (tick_r)
        rxSub_r <= rxSub_r + 4'h1;
      case (rxSt_r)
        RX_IDLE:
        begin
          rxSub_r <= 4'h0;
          if (!rxIn && !rxStop_r && tick_r)
          begin
            rxBit_r <= 4'h0;
            rxSt_r <= RX_DATA;
          end
        end
        RX_DATA:
          if (rxSample)
          begin
            if (rxBit_r != 4'h0)
              rxShift_r <= {rxIn, rxShift_r[7:1]};
            if (rxBit_r == DATA_BITS)
            begin
              rxSt_r <= parSel[2] ? RX_STOP : RX_PAR;
              rxParErr_r <= 1'b0;
            end
            if (rxBit_r == 4'h0 && rxIn)
              rxSt_r <= RX_IDLE;
            rxBit_r <= rxBit_r + 4'h1;
          end
        RX_PAR:
          if (rxSample)
          begin
            rxParErr_r <= rxIn != parityBit(rxShift_r, parSel);
            rxSt_r <= RX_STOP;
          end
        RX_STOP:
          if (rxSample)
            rxSt_r <= RX_IDLE;
        default:
          rxSt_r <= RX_IDLE;
      endcase
    end
  end

  // Last data bit is captured in the same sample that ends RX_DATA
  logic [7:0] rxChar;
  assign rxChar = rxShift_r;

  always_ff @(posedge clk_sys)
  begin
    if (rst || (wrCmd && cmd[CMD_RX_RESET]))
    begin
      rxReady_r <= 1'b0;
      rxHold_r <= 8'h00;
    end
    else if (rxDone)
    begin
      rxReady_r <= 1'b1;
      rxHold_r <= rxChar;
    end
    else if (busReq.rd && hit(busReq, OFF_RX_HOLD))
      rxReady_r <= 1'b0;
  end

  // Set wins over the clear command
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ovr_r <= 1'b0;
      frm_r <= 1'b0;
      par_r <= 1'b0;
    end
    else
    begin
      ovr_r <= (rxDone && rxReady_r) || (ovr_r && !(wrCmd && cmd[CMD_ERR_CLR]));
      frm_r <= (rxDone && !rxIn) || (frm_r && !(wrCmd && cmd[CMD_ERR_CLR]));
      par_r <= (rxDone && rxParErr_r) || (par_r && !(wrCmd && cmd[CMD_ERR_CLR]));
    end
  end

  // ------------------------------------------------------------
  // Status, read data and pins
  // ------------------------------------------------------------
  always_comb
  begin
    status = 32'h0000_0000;
    status[ST_RX_READY] = rxReady_r && receiver_enable_cmd_r;
    status[ST_TX_READY] = transmitter_enable_cmd_r && !txHoldFull_r;
    status[ST_RX_DMA_END] = sideIn.rxDmaEnd;
    status[ST_TX_DMA_END] = sideIn.txDmaEnd;
    status[ST_OVERRUN] = ovr_r;
    status[ST_FRAMING] = frm_r;
    status[ST_PARITY] = par_r;
    status[ST_TX_IDLE] = transmitter_enable_cmd_r && !txHoldFull_r && txSt_r == TX_IDLE;
    status[ST_TX_BUF_EMPTY] = sideIn.txDmaBufferEmpty;
    status[ST_RX_BUF_FULL] = sideIn.rxDmaBufferFull;
    status[ST_DBG_WRITE] = sideIn.debugWritePending;
    status[ST_DBG_READ] = sideIn.debugReadPending;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || !busReq.rd)
      busRdata <= 32'h0000_0000;
    else
      case (busReq.addr)
        OFF_MODE: busRdata <= mode_r;
        OFF_IRQ_VIEW: busRdata <= irqMask_r;
        OFF_STATE: busRdata <= status;
        OFF_RX_HOLD: busRdata <= {24'h000000, rxHold_r};
        OFF_BAUD: busRdata <= {16'h0000, baud_r};
        OFF_CHIP_ID: busRdata <= CHIP_ID;
        OFF_CHIP_EXT: busRdata <= CHIP_EXT;
        OFF_TEST_LOCK: busRdata <= {31'h00000000, lock_r};
        default: busRdata <= 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      serialTxPin <= 1'b1;
      rxDmaRequest <= 1'b0;
      txDmaRequest <= 1'b0;
      testPortLock <= 1'b0;
    end
    else
    begin
      case (channel_test_mode)
        CH_ECHO: serialTxPin <= rxSync_r[1];
        CH_LOCAL: serialTxPin <= 1'b1;
        CH_REMOTE: serialTxPin <= rxSync_r[1];
        default: serialTxPin <= txLine_r;
      endcase
      rxDmaRequest <= status[ST_RX_READY];
      txDmaRequest <= status[ST_TX_READY];
      testPortLock <= lock_r;
    end
  end

endmodule

// *** verif/dbu_serial_host.sv ***
/*
  Remote serial host: sends frames on the receive pin and catches frames from the
  transmit pin. Assumes a bit time of BIT_CYC system clocks and a parity slot.
*/
`timescale 1ns/1ps
module dbu_serial_host #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk_sys,
  input wire logic serialTxPin,
  output logic serialRxPin
);
  logic [8:0] seen[$];

  initial serialRxPin = 1'b1;

  // ------------------------------------------------------------
  // Sender: start, data low bit first, parity, stop
  // ------------------------------------------------------------
  task automatic send(input logic [7:0] d, input logic p, input logic stopBit);
    logic [10:0] f;
    f = {stopBit, p, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      serialRxPin <= f[i];
      repeat (BIT_CYC) @(posedge clk_sys);
    end
    serialRxPin <= 1'b1;
    repeat (BIT_CYC) @(posedge clk_sys);
  endtask

  // ------------------------------------------------------------
  // Catcher: samples mid bit, keeps data and ninth bit
  // ------------------------------------------------------------
  initial
  begin
    logic [8:0] v;
    forever
    begin
      @(negedge serialTxPin);
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      for (int i = 0; i < 9; i++)
      begin
        repeat (BIT_CYC) @(posedge clk_sys);
        v[i] = serialTxPin;
      end
      repeat (BIT_CYC) @(posedge clk_sys);
      seen.push_back(v);
    end
  end
endmodule

// *** verif/dbu_uart_properties.sv ***
/*
  Port-level checker for the debug UART register block, bound to dbu_uart.
  Assumes the plain register port and one clock with synchronous reset.
*/
`timescale 1ns/1ps
module dbu_uart_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire dbu_pkg::dbu_bus_req_t busReq,
  input wire logic [31:0] busRdata,
  input wire dbu_pkg::dbu_side_in_t sideIn,
  input wire logic serialRxPin,
  input wire logic serialTxPin,
  input wire logic rxDmaRequest,
  input wire logic txDmaRequest,
  input wire logic testPortLock
);
  import dbu_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic rdSt;
  logic rdView;
  logic rdMode;
  logic rdRes;
  logic wrCmd;
  assign rdSt = busReq.rd && busReq.addr == OFF_STATE;
  assign rdView = busReq.rd && busReq.addr == OFF_IRQ_VIEW;
  assign rdMode = busReq.rd && busReq.addr == OFF_MODE;
  assign rdRes = busReq.rd && busReq.addr inside {[8'h24:8'h3c], [8'h4c:8'hff],
    OFF_COMMAND, OFF_IRQ_SET, OFF_IRQ_CLEAR, OFF_TX_HOLD};
  assign wrCmd = busReq.wr && busReq.addr == OFF_COMMAND;

  // Tracks whether the last mode write chose local loopback
  logic locMode_r;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      locMode_r <= 1'b0;
    else if (busReq.wr && busReq.addr == OFF_MODE)
      locMode_r <= busReq.wdata[MODE_CH_HI:MODE_CH_LO] == 2'h2;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_rdata_only_answer: assert property (busRdata != 32'h0 |-> $past(busReq.rd))
    else $error("read data outside a read answer");
  a_reserved_reads_zero: assert property (rdRes |=> busRdata == 32'h0)
    else $error("reserved or write-only offset read nonzero");
  a_dma_end_bits: assert property (rdSt |=>
    busRdata[4:3] == {$past(sideIn.txDmaEnd), $past(sideIn.rxDmaEnd)})
    else $error("dma end bits do not follow channel");
  a_dma_buffer_bits: assert property (rdSt |=>
    busRdata[12:11] == {$past(sideIn.rxDmaBufferFull), $past(sideIn.txDmaBufferEmpty)})
    else $error("dma buffer bits do not follow channel");
  a_debug_pending_bits: assert property (rdSt |=>
    busRdata[31:30] == {$past(sideIn.debugReadPending), $past(sideIn.debugWritePending)})
    else $error("debug pending bits do not follow inputs");
  a_mask_view_layout: assert property (rdView |=> (busRdata & ~IRQ_MASK) == 32'h0)
    else $error("mask view has bits outside layout");
  a_mode_field_only: assert property (rdMode |=> (busRdata & ~MODE_MASK) == 32'h0)
    else $error("mode read has bits outside fields");
  a_dma_request_copy: assert property (rdSt |=> {txDmaRequest, rxDmaRequest} == busRdata[1:0])
    else $error("dma requests differ from ready bits");
  a_tx_reset_halt: assert property (wrCmd && busReq.wdata[3] && !busReq.wdata[6] |-> ##2 !txDmaRequest)
    else $error("transmit request after transmitter reset");
  a_rx_reset_halt: assert property (wrCmd && busReq.wdata[2] && !busReq.wdata[4] |-> ##2 !rxDmaRequest)
    else $error("receive request after receiver reset");
  a_local_pin_high: assert property (locMode_r |=> serialTxPin)
    else $error("transmit pin not held high in local loopback");

  c_overrun_seen: cover property (rdSt ##1 busRdata[5]);
  c_rx_ready_seen: cover property (rdSt ##1 busRdata[0]);
  c_tx_request_rise: cover property ($rose(txDmaRequest));
endmodule

bind dbu_uart dbu_uart_properties dbu_uart_properties_i (.clk_sys(clk_sys), .rst(rst),
  .busReq(busReq), .busRdata(busRdata), .sideIn(sideIn), .serialRxPin(serialRxPin),
  .serialTxPin(serialTxPin), .rxDmaRequest(rxDmaRequest), .txDmaRequest(txDmaRequest),
  .testPortLock(testPortLock));

// *** verif/tb_top.sv ***
/*
  Self-checking bench for the debug UART register block.
  Assumes the serial host model on the pins and baud divisor 1 (16 clocks a bit).
*/
`timescale 1ns/1ps
module tb_top;
  import dbu_pkg::*;

  logic clk_sys = 1'b0;
  logic rst;
  dbu_bus_req_t busReq;
  logic [31:0] busRdata;
  dbu_side_in_t sideIn;
  logic serialRxPin;
  logic serialTxPin;
  logic rxDmaRequest;
  logic txDmaRequest;
  logic testPortLock;
  int err_total = 0;
  int checked = 0;
  logic [31:0] lf;
  logic [31:0] mdMask;
  logic [8:0] txQ[$];
  logic [7:0] ra[8] = '{8'h00, 8'h08, 8'h0c, 8'h1c, 8'h24, 8'h3c, 8'h4c, 8'hfc};

  always #5 clk_sys = ~clk_sys;

  dbu_uart dbu_uart_i (.clk_sys(clk_sys), .rst(rst), .busReq(busReq), .busRdata(busRdata),
    .sideIn(sideIn), .serialRxPin(serialRxPin), .serialTxPin(serialTxPin),
    .rxDmaRequest(rxDmaRequest), .txDmaRequest(txDmaRequest), .testPortLock(testPortLock));
  dbu_serial_host dbu_serial_host_i (.clk_sys(clk_sys), .serialTxPin(serialTxPin),
    .serialRxPin(serialRxPin));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic parExp(input int p, input logic [7:0] d);
    if (p > 3) return 1'b1;
    if (p > 1) return p[0];
    return p[0] ^ (^d);
  endfunction

  function automatic logic [31:0] sideExp(input dbu_side_in_t s);
    return {s.debugReadPending, s.debugWritePending, 17'h0, s.rxDmaBufferFull,
      s.txDmaBufferEmpty, 6'h0, s.txDmaEnd, s.rxDmaEnd, 3'h0};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    busReq <= '0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    busReq <= '0;
    #1 v = busRdata;
    @(posedge clk_sys);
    chk(v & m, e & m);
  endtask

  task automatic waitq(input int n);
    int k;
    k = 0;
    while (dbu_serial_host_i.seen.size() < n && k < 3000)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 3000)
    begin
      err_total++;
      $display("Error at %0t: serial frame not seen", $time);
      stop_test;
    end
  endtask

  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk_sys);
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    int n;
    rst = 1'b1;
    busReq = '0;
    sideIn = '0;
    lf = 32'h23;
    mdMask = 32'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdc(OFF_MODE, '1, MODE_RESET);
    rdc(OFF_IRQ_VIEW, '1, IRQ_RESET);
    rdc(OFF_STATE, '1, 32'h0);
    rdc(OFF_RX_HOLD, '1, 32'h0);
    rdc(OFF_TEST_LOCK, '1, 32'h0);
    wr(OFF_TEST_LOCK, 32'h1);
    rdc(OFF_TEST_LOCK, '1, 32'h1);
    chk(32'(testPortLock), 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      lf = nxt(lf);
      if (i > 3) wr(ra[i], lf);
      rdc(ra[i], '1, 32'h0);
    end
    rdc(OFF_MODE, '1, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      lf = nxt(lf);
      if (i[0])
      begin
        wr(OFF_IRQ_CLEAR, lf);
        mdMask &= ~lf;
      end
      else
      begin
        wr(OFF_IRQ_SET, lf);
        mdMask |= lf & IRQ_MASK;
      end
      rdc(OFF_IRQ_VIEW, '1, mdMask);
    end
    for (int i = 0; i < 8; i++)
    begin
      lf = nxt(lf);
      sideIn <= lf[5:0];
      @(posedge clk_sys);
      rdc(OFF_STATE, 32'hc000_1818, sideExp(lf[5:0]));
      wr(OFF_MODE, (lf & ~MODE_MASK) | (32'(i) << MODE_PAR_LO) | (32'(i % 4) << MODE_CH_LO));
      rdc(OFF_MODE, '1, (32'(i) << MODE_PAR_LO) | (32'(i % 4) << MODE_CH_LO));
    end
    sideIn <= '0;
    // Transmit: parity codes 0 to 4, then back to back with disable
    wr(OFF_BAUD, 32'h1);
    wr(OFF_COMMAND, 32'h40);
    rdc(OFF_STATE, 32'h202, 32'h202);
    for (int p = 0; p < 5; p++)
    begin
      lf = nxt(lf);
      wr(OFF_MODE, 32'(p) << MODE_PAR_LO);
      wr(OFF_TX_HOLD, lf & 32'hff);
      txQ.push_back({parExp(p, lf[7:0]), lf[7:0]});
      waitq(1);
      chk(32'(dbu_serial_host_i.seen.pop_front()), 32'(txQ.pop_front()));
    end
    wr(OFF_MODE, 32'h0);
    wr(OFF_TX_HOLD, 32'h5c);
    repeat (4) @(posedge clk_sys);
    wr(OFF_TX_HOLD, 32'ha3);
    rdc(OFF_STATE, 32'h202, 32'h0);
    wr(OFF_COMMAND, 32'h80);
    waitq(2);
    chk(32'(dbu_serial_host_i.seen.pop_front()), {23'h0, ^8'h5c, 8'h5c});
    chk(32'(dbu_serial_host_i.seen.pop_front()), {23'h0, ^8'ha3, 8'ha3});
    repeat (16) @(posedge clk_sys);
    wr(OFF_COMMAND, 32'hc0);
    rdc(OFF_STATE, 32'h202, 32'h0);
    wr(OFF_COMMAND, 32'h40);
    wr(OFF_TX_HOLD, 32'h0);
    repeat (40) @(posedge clk_sys);
    wr(OFF_COMMAND, 32'h8);
    n = 0;
    repeat (300)
    begin
      @(posedge clk_sys);
      n += int'(serialTxPin);
    end
    chk(32'(n), 32'd300);
    dbu_serial_host_i.seen.delete();
    // Receive: ready, overrun, parity, framing, clear
    wr(OFF_COMMAND, 32'h10);
    dbu_serial_host_i.send(8'h3c, ^8'h3c, 1'b1);
    rdc(OFF_STATE, 32'h1, 32'h1);
    rdc(OFF_RX_HOLD, 32'hff, 32'h3c);
    rdc(OFF_STATE, 32'h1, 32'h0);
    dbu_serial_host_i.send(8'h81, ^8'h81, 1'b1);
    dbu_serial_host_i.send(8'h7e, ^8'h7e, 1'b1);
    rdc(OFF_STATE, 32'he1, 32'h21);
    rdc(OFF_RX_HOLD, 32'hff, 32'h7e);
    dbu_serial_host_i.send(8'h19, ~^8'h19, 1'b1);
    rdc(OFF_STATE, 32'h80, 32'h80);
    dbu_serial_host_i.send(8'h19, ^8'h19, 1'b0);
    rdc(OFF_STATE, 32'h40, 32'h40);
    wr(OFF_COMMAND, 32'h100);
    rdc(OFF_STATE, 32'he0, 32'h0);
    fork
      dbu_serial_host_i.send(8'h55, ^8'h55, 1'b1);
      begin
        repeat (60) @(posedge clk_sys);
        wr(OFF_COMMAND, 32'h4);
      end
    join
    wr(OFF_COMMAND, 32'h10);
    rdc(OFF_STATE, 32'h1, 32'h0);
    fork
      dbu_serial_host_i.send(8'h5a, ^8'h5a, 1'b1);
      begin
        repeat (60) @(posedge clk_sys);
        wr(OFF_COMMAND, 32'h20);
      end
    join
    wr(OFF_COMMAND, 32'h10);
    rdc(OFF_STATE, 32'h1, 32'h1);
    rdc(OFF_RX_HOLD, 32'hff, 32'h5a);
    wr(OFF_COMMAND, 32'h30);
    dbu_serial_host_i.send(8'h11, ^8'h11, 1'b1);
    wr(OFF_COMMAND, 32'h10);
    rdc(OFF_STATE, 32'h1, 32'h0);
    // Test modes: echo, remote loop, local loop
    for (int k = 0; k < 2; k++)
    begin
      d = 8'h96 + 8'(k);
      wr(OFF_MODE, k ? 32'hc000 : 32'h4000);
      dbu_serial_host_i.send(d, ^d, 1'b1);
      waitq(1);
      chk(32'(dbu_serial_host_i.seen.pop_front()), {23'h0, ^d, d});
    end
    wr(OFF_MODE, 32'h8000);
    wr(OFF_COMMAND, 32'h50);
    wr(OFF_TX_HOLD, 32'h33);
    n = 0;
    repeat (250)
    begin
      @(posedge clk_sys);
      n += int'(serialTxPin);
    end
    chk(32'(n), 32'd250);
    rdc(OFF_RX_HOLD, 32'hff, 32'h33);
    stop_test;
  end
endmodule
